// ===== hdl/torque_dio.sv
// Purpose: Torque limit clamp, digital I/O objects, early dictionary entries
// Assumes: All inputs synchronous to CLK; one request per cycle at most
// Notes:   Answer (ACK or ABORT) one cycle after a request
`timescale 1ns/1ps
module torque_dio
    import torque_dio_pkg::*;
#(
    parameter logic [31:0] VENDOR_CODE  = 32'h0000_0001, // Arbitrary value
    parameter logic [31:0] PRODUCT_CODE = 32'h0000_0002, // Arbitrary value
    parameter logic [31:0] REVISION     = 32'h0000_0003, // Arbitrary value
    parameter logic [31:0] SERIAL       = 32'h0000_0004  // Arbitrary value
) (
    input  wire logic        CLK,
    input  wire logic        SRST,
    input  wire acc_s        ACC,
    output logic             ACK,
    output logic             ABORT,
    output logic [31:0]      RD_DATA,
    input  wire logic [15:0] TORQUE_REF,
    output logic [15:0]      TORQUE_OUT,
    input  wire logic        NEG_OT,
    input  wire logic        POS_OT,
    input  wire logic        HOME_SW,
    input  wire logic [4:0]  GP_IN,
    input  wire logic [4:0]  IN_REMOTE,
    output logic [4:0]       FUNC_IN,
    input  wire logic [3:0]  OUT_ASSIGN,
    input  wire logic [3:0]  BUS_OUT_EN,
    input  wire logic [3:0]  OUT_POLARITY,
    input  wire logic [3:0]  REMOTE_ASSIGN,
    output logic [3:0]       GP_OUT,
    output logic [3:0]       REMOTE_OUT,
    input  wire logic        ERR_EVENT,
    input  wire logic [31:0] ERR_CODE,
    output logic             SAVE_PULSE
);
    // ==========================================================
    // State
    logic [15:0] max_tq, pos_tq, neg_tq;
    logic [15:0] next_max_tq, next_pos_tq, next_neg_tq;
    logic [31:0] dout_val, dout_mask, next_dout_val, next_dout_mask;
    logic [31:0] hist [8];
    logic [31:0] next_hist [8];
    logic [7:0]  err_cnt, next_err_cnt;
    logic [31:0] store_cmd, next_store_cmd;
    logic [31:0] rmap [2][8];
    logic [31:0] next_rmap [2][8];
    logic [7:0]  rmap_cnt [2];
    logic [7:0]  next_rmap_cnt [2];
    logic        next_ack, next_abort, next_save;
    logic [31:0] next_rd, din;
    logic [15:0] eff_pos, eff_neg, next_tq;
    logic [4:0]  next_func;
    logic [3:0]  next_gp, next_rem, gp_take;

    function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
        return (a < b) ? a : b;
    endfunction : min16

    // Subindex 1..8 of a list object, index 0..7 when valid
    function automatic logic list_ok(input logic [7:0] s);
        return (s != 8'h00) && (s <= LIST_DEPTH);
    endfunction : list_ok

    // ==========================================================
    // Torque limit
    always_comb begin
        logic signed [16:0] r, lp, ln;
        eff_pos = min16(max_tq, pos_tq);
        eff_neg = min16(max_tq, neg_tq);
        r  = {TORQUE_REF[15], TORQUE_REF};
        lp = {1'b0, eff_pos};
        ln = -{1'b0, eff_neg};
        // Limits above 32767 cannot be reached by a 16-bit reference
        if (r > lp) begin
            next_tq = lp[15:0];
        end else if (r < ln) begin
            next_tq = ln[15:0];
        end else begin
            next_tq = TORQUE_REF;
        end
    end

    // ==========================================================
    // Digital inputs and outputs
    always_comb begin
        din = '0;
        din[BIT_NEG_OT] = NEG_OT;
        din[BIT_POS_OT] = POS_OT;
        din[BIT_HOME]   = HOME_SW;
        din[GP_LSB +: 5] = GP_IN;
        next_func = ~GP_IN & ~IN_REMOTE;
        // A bus bit counts only if masked in, assigned and bus-enabled
        gp_take = dout_mask[GP_LSB +: 4] & OUT_ASSIGN & BUS_OUT_EN;
        // Low bit means active; untaken outputs rest inactive
        next_gp = (gp_take & ~dout_val[GP_LSB +: 4]) ^ OUT_POLARITY;
        next_rem = dout_val[REMOTE_LSB +: 4] & dout_mask[REMOTE_LSB +: 4]
                   & REMOTE_ASSIGN;
    end

    // ==========================================================
    // Object access
    always_comb begin
        logic [2:0] li;
        logic       hit, rw;
        li = ACC.sub[2:0] - 3'h1;
        next_max_tq = max_tq;
        next_pos_tq = pos_tq;
        next_neg_tq = neg_tq;
        next_dout_val = dout_val;
        next_dout_mask = dout_mask;
        next_hist = hist;
        next_err_cnt = err_cnt;
        next_store_cmd = store_cmd;
        next_rmap = rmap;
        next_rmap_cnt = rmap_cnt;
        next_rd = '0;
        next_save = 1'b0;
        hit = 1'b0;
        rw = 1'b0;
        // New errors push in at entry 1; oldest falls off the end
        if (ERR_EVENT) begin
            for (int i = 7; i > 0; i--) begin
                next_hist[i] = hist[i-1];
            end
            next_hist[0] = ERR_CODE;
            if (err_cnt < LIST_DEPTH) begin
                next_err_cnt = err_cnt + 8'h01;
            end
        end
        if (ACC.index == IDX_MAX_TQ && ACC.sub == 8'h00) begin
            hit = 1'b1;
            rw = 1'b1;
            next_rd = {16'h0000, max_tq};
            if (ACC.wr) begin
                next_max_tq = ACC.wdata[15:0];
            end
        end else if (ACC.index == IDX_POS_TQ && ACC.sub == 8'h00) begin
            hit = 1'b1;
            rw = 1'b1;
            next_rd = {16'h0000, pos_tq};
            if (ACC.wr) begin
                next_pos_tq = ACC.wdata[15:0];
            end
        end else if (ACC.index == IDX_NEG_TQ && ACC.sub == 8'h00) begin
            hit = 1'b1;
            rw = 1'b1;
            next_rd = {16'h0000, neg_tq};
            if (ACC.wr) begin
                next_neg_tq = ACC.wdata[15:0];
            end
        end else if (ACC.index == IDX_DIN && ACC.sub == 8'h00) begin
            hit = 1'b1;
            next_rd = din;
        end else if (ACC.index == IDX_DOUT && ACC.sub == 8'h00) begin
            hit = 1'b1;
            next_rd = {24'h0, DOUT_SUBS};
        end else if (ACC.index == IDX_DOUT && ACC.sub == 8'h01) begin
            hit = 1'b1;
            rw = 1'b1;
            next_rd = dout_val;
            if (ACC.wr) begin
                next_dout_val = ACC.wdata & DOUT_WMASK;
            end
        end else if (ACC.index == IDX_DOUT && ACC.sub == 8'h02) begin
            hit = 1'b1;
            rw = 1'b1;
            next_rd = dout_mask;
            if (ACC.wr) begin
                next_dout_mask = ACC.wdata & DOUT_WMASK;
            end
        end else if (ACC.index == IDX_ERR_HIST && ACC.sub == 8'h00) begin
            hit = 1'b1;
            next_rd = {24'h0, err_cnt};
        end else if (ACC.index == IDX_ERR_HIST && list_ok(ACC.sub)) begin
            hit = 1'b1;
            next_rd = hist[li];
        end else if (ACC.index == IDX_STORE && ACC.sub == 8'h00) begin
            hit = 1'b1;
            next_rd = {24'h0, STORE_SUBS};
        end else if (ACC.index == IDX_STORE && (ACC.sub == 8'h01 || ACC.sub == 8'h02)) begin
            hit = 1'b1;
        end else if (ACC.index == IDX_STORE && ACC.sub == SUB_STORE_CMD) begin
            hit = 1'b1;
            rw = 1'b1;
            next_rd = store_cmd;
            if (ACC.wr) begin
                next_store_cmd = ACC.wdata;
                next_save = 1'b1;
            end
        end else if (ACC.index == IDX_IDENT && ACC.sub <= IDENT_SUBS) begin
            hit = 1'b1;
            if (ACC.sub == 8'h00) next_rd = {24'h0, IDENT_SUBS};
            else if (ACC.sub == 8'h01) next_rd = VENDOR_CODE;
            else if (ACC.sub == 8'h02) next_rd = PRODUCT_CODE;
            else if (ACC.sub == 8'h03) next_rd = REVISION;
            else next_rd = SERIAL;
        end else if (ACC.index == IDX_RMAP0 || ACC.index == IDX_RMAP1) begin
            if (ACC.sub == 8'h00) begin
                hit = !(ACC.wr && ACC.wdata[7:0] > LIST_DEPTH);
                rw = 1'b1;
                next_rd = {24'h0, rmap_cnt[ACC.index[0]]};
                if (ACC.wr && hit) begin
                    next_rmap_cnt[ACC.index[0]] = ACC.wdata[7:0];
                end
            end else if (list_ok(ACC.sub)) begin
                hit = 1'b1;
                rw = 1'b1;
                next_rd = rmap[ACC.index[0]][li];
                if (ACC.wr) begin
                    next_rmap[ACC.index[0]][li] = ACC.wdata;
                end
            end
        end
        // Writes to read-only objects abort; data stays untouched
        next_ack = (ACC.wr || ACC.rd) && hit && (rw || !ACC.wr);
        next_abort = (ACC.wr || ACC.rd) && !(hit && (rw || !ACC.wr));
        if (!ACC.rd || !next_ack) begin
            next_rd = '0;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            max_tq <= MAX_TQ_RST;
            pos_tq <= POS_TQ_RST;
            neg_tq <= NEG_TQ_RST;
            dout_val <= DOUT_RST;
            dout_mask <= DOUT_RST;
            hist <= '{default: '0};
            err_cnt <= '0;
            store_cmd <= '0;
            rmap <= '{default: '{default: '0}};
            rmap_cnt <= '{default: '0};
            ACK <= 1'b0;
            ABORT <= 1'b0;
            RD_DATA <= '0;
            SAVE_PULSE <= 1'b0;
            TORQUE_OUT <= '0;
            FUNC_IN <= '0;
            GP_OUT <= '0;
            REMOTE_OUT <= '0;
        end else begin
            max_tq <= next_max_tq;
            pos_tq <= next_pos_tq;
            neg_tq <= next_neg_tq;
            dout_val <= next_dout_val;
            dout_mask <= next_dout_mask;
            hist <= next_hist;
            err_cnt <= next_err_cnt;
            store_cmd <= next_store_cmd;
            rmap <= next_rmap;
            rmap_cnt <= next_rmap_cnt;
            ACK <= next_ack;
            ABORT <= next_abort;
            RD_DATA <= next_rd;
            SAVE_PULSE <= next_save;
            TORQUE_OUT <= next_tq;
            FUNC_IN <= next_func;
            GP_OUT <= next_gp;
            REMOTE_OUT <= next_rem;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence din_read;
        ACC.rd && ACC.index == IDX_DIN && ACC.sub == 8'h00;
    endsequence
    sequence store_write;
        ACC.wr && ACC.index == IDX_STORE && ACC.sub == SUB_STORE_CMD;
    endsequence

    AST_MAX_RST: assert property (disable iff (1'b0) SRST |=> max_tq == MAX_TQ_RST)
        else $error("max torque not reset to default");
    AST_POS_LIM: assert property ($signed(TORQUE_REF) > $signed({1'b0, eff_pos})
        |=> TORQUE_OUT == $past(eff_pos))
        else $error("positive torque clamp wrong");
    AST_NEG_LIM: assert property ($signed(TORQUE_REF) < -$signed({1'b0, eff_neg})
        |=> TORQUE_OUT == 16'(-$past(eff_neg)))
        else $error("negative torque clamp wrong");
    AST_DIN_READ: assert property (din_read |=> ACK ##0
        RD_DATA[2:0] == {$past(HOME_SW), $past(POS_OT), $past(NEG_OT)})
        else $error("input state bits wrong");
    AST_REMOTE_IN: assert property (1'b1 |=> (FUNC_IN & $past(IN_REMOTE)) == 5'h00)
        else $error("remote input used locally");
    AST_MASK_OFF: assert property ((dout_mask[19:16] == 4'h0) |=>
        GP_OUT == $past(OUT_POLARITY))
        else $error("unmasked output took effect");
    AST_RESERVED: assert property (((dout_val | dout_mask) & ~DOUT_WMASK) == 32'h0)
        else $error("reserved output bit set");
    AST_ERR_CNT: assert property (ERR_EVENT && err_cnt < LIST_DEPTH
        |=> err_cnt == $past(err_cnt) + 8'h01 && hist[0] == $past(ERR_CODE))
        else $error("error history not updated");
    // Back-to-back store writes legally give back-to-back pulses
    AST_STORE: assert property (store_write |=> SAVE_PULSE)
        else $error("save pulse missing");
    AST_SAVE_SRC: assert property (SAVE_PULSE |->
        $past(ACC.wr && ACC.index == IDX_STORE && ACC.sub == SUB_STORE_CMD))
        else $error("save pulse without store write");
endmodule : torque_dio

// ===== inc/torque_dio_pkg.sv
// Purpose: Constants and carriers for torque limit and digital I/O objects
// Assumes: One object access port addressed by index and subindex
// Notes:   Objects narrower than 32 bits sit in the low bits
package torque_dio_pkg;
    // ==========================================================
    // Object indexes
    localparam logic [15:0] IDX_ERR_HIST = 16'h1003;
    localparam logic [15:0] IDX_STORE    = 16'h1010;
    localparam logic [15:0] IDX_IDENT    = 16'h1018;
    localparam logic [15:0] IDX_RMAP0    = 16'h1600;
    localparam logic [15:0] IDX_RMAP1    = 16'h1601;
    localparam logic [15:0] IDX_MAX_TQ   = 16'h6072;
    localparam logic [15:0] IDX_POS_TQ   = 16'h60e0;
    localparam logic [15:0] IDX_NEG_TQ   = 16'h60e1;
    localparam logic [15:0] IDX_DIN      = 16'h60fd;
    localparam logic [15:0] IDX_DOUT     = 16'h60fe;
    // ==========================================================
    // Subindexes and counts
    localparam logic [7:0]  SUB_STORE_CMD = 8'h03;
    localparam logic [7:0]  DOUT_SUBS     = 8'h02;
    localparam logic [7:0]  STORE_SUBS    = 8'h03;
    localparam logic [7:0]  IDENT_SUBS    = 8'h04;
    localparam logic [7:0]  LIST_DEPTH    = 8'h08;
    // ==========================================================
    // Reset values
    localparam logic [15:0] MAX_TQ_RST = 16'h0bb8;
    localparam logic [15:0] POS_TQ_RST = 16'h0bb8;
    localparam logic [15:0] NEG_TQ_RST = 16'h0bb8;
    localparam logic [31:0] DOUT_RST   = 32'h0000_0000;
    // ==========================================================
    // Field positions
    localparam logic [31:0] DOUT_WMASK = 32'h0f1f_0000;
    localparam int BIT_NEG_OT  = 0;
    localparam int BIT_POS_OT  = 1;
    localparam int BIT_HOME    = 2;
    localparam int GP_LSB      = 16;
    localparam int REMOTE_LSB  = 24;
    // ==========================================================
    // Access request carrier
    typedef struct packed {
        logic [15:0] index;
        logic [7:0]  sub;
        logic        wr;
        logic        rd;
        logic [31:0] wdata;
    } acc_s;
endpackage : torque_dio_pkg

// ===== dv/fieldbus_master.sv
// Purpose: Fieldbus master model that issues object requests to the drive
// Assumes: Answer arrives within three cycles of the taking edge
// Notes:   Released index, subindex and write data show the inverse of their last value; both strobes drop to 0
`timescale 1ns/1ps
module fieldbus_master
    import torque_dio_pkg::*;
(
    input  wire logic        CLK,
    output acc_s             ACC,
    input  wire logic        ACK,
    input  wire logic        ABORT,
    input  wire logic [31:0] RD_DATA,
    input  wire logic        SAVE_PULSE
);
    initial begin
        ACC = '0;
    end
    // ==========================================================
    // One request: strobe for one taking edge, then collect the answer
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sb,
                        input logic [31:0] wd, output logic [31:0] rdat,
                        output logic ab, output logic sv);
        int n;
        @(posedge CLK);
        #2;
        ACC = '{index: idx, sub: sb, wr: w, rd: !w, wdata: wd};
        @(posedge CLK);
        #2;
        // Strobes are pulses, so a held strobe would be a second request
        ACC = '{index: ~idx, sub: ~sb, wr: 1'b0, rd: 1'b0, wdata: ~wd};
        n = 0;
        while (ACK !== 1'b1 && ABORT !== 1'b1 && n < 4) begin
            @(posedge CLK);
            #2;
            n++;
        end
        rdat = RD_DATA;
        ab   = (n < 4) ? ABORT : 1'bx;
        sv   = SAVE_PULSE;
    endtask : xfer
endmodule : fieldbus_master

// ===== dv/testbench.sv
// Purpose: Self-checking bench for torque clamp, digital I/O and dictionary
// Assumes: Master model drives all object requests
// Notes:   Random stimulus from a fixed seed, corner cases mixed in
`timescale 1ns/1ps
module testbench
    import torque_dio_pkg::*;
;
    logic CLK, SRST, ERR_EVENT, NEG_OT, POS_OT, HOME_SW, ACK, ABORT, SAVE_PULSE, last_save;
    logic [15:0] TORQUE_REF, TORQUE_OUT, m, p, n;
    logic [4:0]  GP_IN, IN_REMOTE, FUNC_IN;
    logic [3:0]  OUT_ASSIGN, BUS_OUT_EN, OUT_POLARITY, REMOTE_ASSIGN, GP_OUT, REMOTE_OUT;
    logic [31:0] ERR_CODE, RD_DATA, v, mk, codes [0:8];
    acc_s        ACC;
    int          seed, miscompares, total_checks, cycles;
    localparam logic [31:0] VENDOR = 32'h0000_00a5; // Arbitrary value

    fieldbus_master master (.CLK(CLK), .ACC(ACC), .ACK(ACK), .ABORT(ABORT),
                            .RD_DATA(RD_DATA), .SAVE_PULSE(SAVE_PULSE));
    torque_dio #(.VENDOR_CODE(VENDOR)) dut (.CLK(CLK), .SRST(SRST), .ACC(ACC), .ACK(ACK),
        .ABORT(ABORT), .RD_DATA(RD_DATA), .TORQUE_REF(TORQUE_REF), .TORQUE_OUT(TORQUE_OUT),
        .NEG_OT(NEG_OT), .POS_OT(POS_OT), .HOME_SW(HOME_SW), .GP_IN(GP_IN),
        .IN_REMOTE(IN_REMOTE), .FUNC_IN(FUNC_IN), .OUT_ASSIGN(OUT_ASSIGN),
        .BUS_OUT_EN(BUS_OUT_EN), .OUT_POLARITY(OUT_POLARITY), .REMOTE_ASSIGN(REMOTE_ASSIGN),
        .GP_OUT(GP_OUT), .REMOTE_OUT(REMOTE_OUT), .ERR_EVENT(ERR_EVENT), .ERR_CODE(ERR_CODE),
        .SAVE_PULSE(SAVE_PULSE));
    // ==========================================================
    // Clock, timeout and reporting
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sb,
                       input logic [31:0] wd, input logic [31:0] exp, input logic eab);
        logic [31:0] r;
        logic        a;
        master.xfer(w, idx, sb, wd, r, a, last_save);
        chk({31'h0, a}, {31'h0, eab});
        if (!w && !eab) chk(r, exp);
    endtask : acc
    // Signed reference against the smaller of each limit and the global maximum
    function automatic logic [15:0] clamp(logic [15:0] r, logic [15:0] mx, logic [15:0] ps,
                                          logic [15:0] ng);
        int t, pl, nl;
        t  = $signed(r);
        pl = (ps < mx) ? ps : mx;
        nl = (ng < mx) ? ng : mx;
        if (t > pl) t = pl;
        if (t < -nl) t = -nl;
        return t[15:0];
    endfunction : clamp
    // ==========================================================
    // Main sequence
    initial begin
        seed = 79;
        {miscompares, total_checks, cycles} = '0;
        {SRST, ERR_EVENT, NEG_OT, POS_OT, HOME_SW, TORQUE_REF, ERR_CODE} = '0;
        {GP_IN, IN_REMOTE} = '1;
        {OUT_ASSIGN, BUS_OUT_EN, OUT_POLARITY, REMOTE_ASSIGN} = '0;
        #2 SRST = 1'b1;
        repeat (6) @(posedge CLK);
        #2 SRST = 1'b0;
        chk({28'h0, GP_OUT}, 32'h0);
        acc(0, IDX_MAX_TQ, 0, 0, {16'h0, MAX_TQ_RST}, 0);
        acc(0, IDX_DOUT, 0, 0, {24'h0, DOUT_SUBS}, 0);
        acc(0, IDX_DOUT, 1, 0, DOUT_RST, 0);
        acc(0, IDX_DOUT, 2, 0, DOUT_RST, 0);
        for (int i = 0; i < 16; i++) begin
            m = 16'($random(seed));
            p = (i % 4 == 0) ? 16'h0000 : 16'($random(seed));
            n = (i % 4 == 1) ? 16'hffff : 16'($random(seed)) & 16'h0fff;
            if (i % 4 == 2) m = 16'h0100;
            acc(1, IDX_MAX_TQ, 0, {16'h0, m}, 0, 0);
            acc(1, IDX_POS_TQ, 0, {16'h0, p}, 0, 0);
            acc(1, IDX_NEG_TQ, 0, {16'h0, n}, 0, 0);
            acc(0, IDX_NEG_TQ, 0, 0, {16'h0, n}, 0);
            for (int k = 0; k < 4; k++) begin
                TORQUE_REF = 16'((k == 0) ? 16'h7fff : (k == 1) ? 16'h8000 : $random(seed));
                @(posedge CLK);
                #2;
                chk(32'(TORQUE_OUT), 32'(clamp(TORQUE_REF, m, p, n)));
            end
        end
        // Mid-run reset must bring the torque maximum back to its default
        SRST = 1'b1;
        @(posedge CLK);
        #2 SRST = 1'b0;
        acc(0, IDX_MAX_TQ, 0, 0, {16'h0, MAX_TQ_RST}, 0);
        for (int i = 0; i < 10; i++) begin
            {NEG_OT, POS_OT, HOME_SW, GP_IN, IN_REMOTE} = 13'($random(seed));
            @(posedge CLK);
            #2;
            chk({27'h0, FUNC_IN}, {27'h0, ~GP_IN & ~IN_REMOTE});
            v = {11'h0, GP_IN, 13'h0, HOME_SW, POS_OT, NEG_OT};
            acc(0, IDX_DIN, 0, 0, v, 0);
        end
        for (int i = 0; i < 12; i++) begin
            v = $random(seed);
            {OUT_ASSIGN, BUS_OUT_EN, OUT_POLARITY, REMOTE_ASSIGN} = v[15:0];
            v  = $random(seed);
            mk = (i == 0) ? 32'hffff_ffff : $random(seed);
            acc(1, IDX_DOUT, 1, v, 0, 0);
            acc(1, IDX_DOUT, 2, mk, 0, 0);
            acc(0, IDX_DOUT, 1, 0, v & DOUT_WMASK, 0);
            acc(0, IDX_DOUT, 2, 0, mk & DOUT_WMASK, 0);
            chk({28'h0, GP_OUT},
                {28'h0, ((mk[19:16] & OUT_ASSIGN & BUS_OUT_EN) & ~v[19:16]) ^ OUT_POLARITY});
            chk({28'h0, REMOTE_OUT}, {28'h0, v[27:24] & mk[27:24] & REMOTE_ASSIGN});
        end
        acc(1, IDX_DIN, 0, 32'h1, 0, 1);
        acc(1, 16'h2000, 0, 32'h1, 0, 1);
        acc(0, IDX_ERR_HIST, 0, 0, 32'h0, 0);
        for (int i = 0; i < 9; i++) begin
            @(posedge CLK);
            #2;
            codes[i]  = $random(seed);
            ERR_CODE  = codes[i];
            ERR_EVENT = 1'b1;
            @(posedge CLK);
            #2;
            ERR_EVENT = 1'b0;
            if (i == 2) acc(0, IDX_ERR_HIST, 0, 0, 32'h3, 0);
        end
        acc(0, IDX_ERR_HIST, 0, 0, {24'h0, LIST_DEPTH}, 0);
        acc(0, IDX_ERR_HIST, 1, 0, codes[8], 0);
        acc(0, IDX_ERR_HIST, 8, 0, codes[1], 0);
        acc(1, IDX_ERR_HIST, 1, 32'h1, 0, 1);
        acc(1, IDX_STORE, SUB_STORE_CMD, $random(seed), 0, 0);
        chk({31'h0, last_save}, 32'h1);
        acc(1, IDX_STORE, 1, 32'h1, 0, 1);
        chk({31'h0, last_save}, 32'h0);
        acc(0, IDX_STORE, 0, 0, {24'h0, STORE_SUBS}, 0);
        acc(0, IDX_STORE, 2, 0, 32'h0, 0);
        acc(0, IDX_IDENT, 0, 0, {24'h0, IDENT_SUBS}, 0);
        acc(0, IDX_IDENT, 1, 0, VENDOR, 0);
        acc(1, IDX_IDENT, 1, 32'h1, 0, 1);
        for (int j = 0; j < 2; j++) begin
            m = 16'(IDX_RMAP0 + j);
            acc(0, m, 0, 0, 32'h0, 0);
            acc(1, m, 0, 32'h9, 0, 1);
            acc(1, m, 0, 32'h8, 0, 0);
            acc(1, m, 0, 32'h9, 0, 1);
            acc(0, m, 0, 0, 32'h8, 0);
            acc(1, m, 9, 32'h1, 0, 1);
            for (int k = 1; k <= 8; k++) begin
                v = $random(seed);
                acc(1, m, k[7:0], v, 0, 0);
                acc(0, m, k[7:0], 0, v, 0);
            end
        end
        test_done();
    end
endmodule : testbench
